// ### src/dpms_debug_port.v
// combined debug port: tap shift chains, serial-wire mode switch, pin config, recovery erase
// assumes link pins arrive asynchronous; erase and nonvolatile restore engines are outside
//
// Overview of operation
// - capture states load the chain; shift states present it bit by bit on tdo
// - during shift, tdi bits enter the same chain as bits leave on tdo
// - update-dr copies the chain into the holding register only under the dpacc instruction; otherwise it holds
// - after reset all five pins: digital enable, pull-up, alternate function all one
// - clearing alternate-function bits gives the pins to general-purpose use
// - alternate-function writes are dropped unless unlocked and commit-enable bit set
// - ten switch codes seen while external reset held trigger flash mass erase
// - mass erase completes before nonvolatile registers return to factory defaults
// - the tap preamble walk starts from idle and cannot finish: step 23 wants select-ir right after idle, so it never enables serial-wire
// - serial-wire switch code is 16'hE79E, lsb first, one bit per clock
// - jtag switch code is 16'hE73C, lsb first, one bit per clock
// - 50 high cycles idle both engines; in serial-wire mode enter line reset
// - in jtag mode five high cycles after the code reach test-logic-reset
// - five high tms cycles force test-logic-reset and reload identification instruction
// - tms and tdi are sampled on the link clock rising edge
// - test reset low holds the tap in test-logic-reset asynchronously to the link
`timescale 1ns/10ps
`include "dpms_defs.vh"
module dpms_debug_port (
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire        linkClk,
  input  wire        modeSelIn,
  input  wire        dataIn,
  input  wire        testRst_b,
  input  wire        extRst_b,
  output reg         dataOut,
  output reg         dataOutEn,
  output reg         modeSelOut,
  output reg         modeSelOutEn,
  input  wire [4:0]  afselWrData,
  input  wire        afselWrEn,
  input  wire [4:0]  commitWrData,
  input  wire        commitWrEn,
  input  wire [31:0] lockWrData,
  input  wire        lockWrEn,
  output reg  [4:0]  pin_alt_function_select,
  output reg  [4:0]  pin_digital_enable,
  output reg  [4:0]  pin_pullup_enable,
  output reg  [4:0]  pin_commit_enable,
  output reg         pinConfigUnlocked,
  output reg         serialWireMode,
  output reg         serialLineReset,
  output reg         massEraseReq,
  output reg         nvRestoreReq,
  input  wire        massEraseDone,
  output reg  [3:0]  instruction,
  output reg  [31:0] dataHold
);
  // ----------------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------------
  reg [2:0] clkSync, tmsSync, tdiSync, trstSync, rstSync;
  reg       clkLevel, tmsLevel, tdiLevel;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      clkSync  <= 3'h0;
      tmsSync  <= 3'h7;
      tdiSync  <= 3'h7;
      trstSync <= 3'h0;
      rstSync  <= 3'h7;
      clkLevel <= 1'b0;
      tmsLevel <= 1'b1;
      tdiLevel <= 1'b1;
    end else begin
      clkSync  <= {clkSync[1:0], linkClk};
      tmsSync  <= {tmsSync[1:0], modeSelIn};
      tdiSync  <= {tdiSync[1:0], dataIn};
      trstSync <= {trstSync[1:0], testRst_b};
      rstSync  <= {rstSync[1:0], extRst_b};
      if (clkSync[1] == clkSync[2]) clkLevel <= clkSync[2];
      if (tmsSync[1] == tmsSync[2]) tmsLevel <= tmsSync[2];
      if (tdiSync[1] == tdiSync[2]) tdiLevel <= tdiSync[2];
    end
  end
  wire tckRise = (clkSync[1] == clkSync[2]) && clkSync[2] && !clkLevel;
  wire tckFall = (clkSync[1] == clkSync[2]) && !clkSync[2] && clkLevel;
  wire testRst = !trstSync[2];
  wire extRstOn = !rstSync[2];

  // ----------------------------------------------------------------------
  // tap controller
  // ----------------------------------------------------------------------
  wire [15:0] tapState;
  dpms_tap_fsm uTap (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .testRst  (testRst | serialWireMode),
    .tckRise  (tckRise),
    .tms      (tmsLevel),
    .tapState (tapState)
  );
  localparam [15:0] S_TLR  = 16'h0001, S_IDLE = 16'h0002, S_SELDR = 16'h0004, S_CAPDR = 16'h0008,
                    S_SHDR = 16'h0010, S_UPDR = 16'h0100, S_SELIR = 16'h0200, S_CAPIR = 16'h0400,
                    S_SHIR = 16'h0800, S_UPIR = 16'h8000;

  // ----------------------------------------------------------------------
  // shift chains
  // ----------------------------------------------------------------------
  reg [3:0]  irChain;
  reg [31:0] drChain;
  reg        bypassBit;
  wire       drIsWide = (instruction == `DPMS_IR_IDENT) || (instruction == `DPMS_IR_DPACC);
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irChain     <= 4'h0;
      drChain     <= 32'h0;
      bypassBit   <= 1'b0;
      instruction <= `DPMS_IR_IDENT;
      dataHold    <= 32'h0;
    end else if (tapState == S_TLR) begin
      instruction <= `DPMS_IR_IDENT;
    end else if (tckRise) begin
      case (tapState)
        S_CAPIR: irChain <= 4'h1;
        S_SHIR:  irChain <= {tdiLevel, irChain[3:1]};
        S_CAPDR: begin
          drChain   <= (instruction == `DPMS_IR_IDENT) ? `DPMS_IDENT_VALUE : dataHold;
          bypassBit <= 1'b0;
        end
        S_SHDR: begin
          drChain   <= {tdiLevel, drChain[31:1]};
          bypassBit <= tdiLevel;
        end
        S_UPIR:  instruction <= irChain;
        S_UPDR:  if (instruction == `DPMS_IR_DPACC) dataHold <= drChain;
        default: dataHold <= dataHold;
      endcase
    end
  end

  // tdo changes on the falling link clock edge, driven only while shifting
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dataOut   <= 1'b0;
      dataOutEn <= 1'b0;
    end else if (tckFall) begin
      dataOutEn <= ((tapState == S_SHIR) || (tapState == S_SHDR)) && !serialWireMode;
      dataOut   <= (tapState == S_SHIR) ? irChain[0] : (drIsWide ? drChain[0] : bypassBit);
    end
  end
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      modeSelOut   <= 1'b0;
      modeSelOutEn <= 1'b0;
    end else begin
      modeSelOut   <= 1'b0;
      modeSelOutEn <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // mode detector
  // ----------------------------------------------------------------------
  reg [15:0] tmsHist;
  reg [5:0]  highRun;
  reg        armed;
  reg [4:0]  codeCnt;
  reg [4:0]  preStep;
  wire       matchSerial = ({tmsLevel, tmsHist[15:1]} == `DPMS_CODE_TO_SERIAL);
  wire       matchJtag   = ({tmsLevel, tmsHist[15:1]} == `DPMS_CODE_TO_JTAG);

  function [15:0] preambleState;
    input [4:0] idx;
    begin
      case (idx)
        5'd0, 5'd5, 5'd6, 5'd11, 5'd12, 5'd16, 5'd17, 5'd21, 5'd22: preambleState = S_IDLE;
        5'd1, 5'd7, 5'd13, 5'd18:                                   preambleState = S_SELDR;
        5'd2, 5'd8, 5'd14, 5'd19, 5'd23:                            preambleState = S_SELIR;
        default:                                                    preambleState = S_TLR;
      endcase
    end
  endfunction

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tmsHist         <= 16'hFFFF;
      highRun         <= 6'h0;
      armed           <= 1'b0;
      codeCnt         <= 5'h0;
      serialWireMode  <= 1'b0;
      serialLineReset <= 1'b0;
      preStep         <= 5'h0;
    end else if (tckRise) begin
      tmsHist <= {tmsLevel, tmsHist[15:1]};
      if (tmsLevel && highRun != `DPMS_HIGH_RUN_MIN) highRun <= highRun + 6'h1;
      else if (!tmsLevel) highRun <= 6'h0;
      // the fiftieth high sample arms the detector, so a code may follow at once
      if (tmsLevel && highRun == (`DPMS_HIGH_RUN_MIN - 6'h1)) armed <= 1'b1;
      serialLineReset <= serialWireMode && tmsLevel && (highRun == (`DPMS_HIGH_RUN_MIN - 6'h1));
      if (armed && codeCnt == 5'hF) begin
        armed   <= 1'b0;
        codeCnt <= 5'h0;
        if (matchSerial) serialWireMode <= 1'b1;
        if (matchJtag)   serialWireMode <= 1'b0;
      end else if (armed && !tmsLevel) begin
        codeCnt <= codeCnt + 5'h1;
      end else if (armed && codeCnt != 5'h0) begin
        codeCnt <= codeCnt + 5'h1;
      end
      // preamble walk through tap states
      if (!serialWireMode) begin
        if (tapState == preambleState(preStep) && (preStep != 5'h0 || tapState == S_IDLE)) begin
          if (preStep == 5'd24) begin
            serialWireMode <= 1'b1;
            preStep        <= 5'h0;
          end else begin
            preStep <= preStep + 5'h1;
          end
        end else begin
          preStep <= 5'h0;
        end
      end
    end else if (!tckRise) begin
      serialLineReset <= serialLineReset;
    end
  end
  wire codeSeen = tckRise && armed && (codeCnt == 5'hF) && (matchSerial || matchJtag);

  // ----------------------------------------------------------------------
  // recovery counter and erase sequencing
  // ----------------------------------------------------------------------
  reg [3:0] recoverCnt;
  reg       eraseBusy;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      recoverCnt   <= 4'h0;
      massEraseReq <= 1'b0;
      nvRestoreReq <= 1'b0;
      eraseBusy    <= 1'b0;
    end else begin
      nvRestoreReq <= 1'b0;
      if (!extRstOn) begin
        recoverCnt <= 4'h0;
      end else if (codeSeen && recoverCnt != `DPMS_ERASE_COUNT) begin
        recoverCnt <= recoverCnt + 4'h1;
      end
      if (extRstOn && recoverCnt == `DPMS_ERASE_COUNT && !eraseBusy && !massEraseReq) begin
        massEraseReq <= 1'b1;
        eraseBusy    <= 1'b1;
      end else if (eraseBusy && massEraseDone) begin
        // one erase per recovery: a stale count must not request it again
        recoverCnt   <= 4'h0;
        massEraseReq <= 1'b0;
        eraseBusy    <= 1'b0;
        nvRestoreReq <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // pin configuration and commit protection
  // ----------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_alt_function_select <= `DPMS_PIN_DEFAULT;
      pin_digital_enable      <= `DPMS_PIN_DEFAULT;
      pin_pullup_enable       <= `DPMS_PIN_DEFAULT;
      pin_commit_enable       <= 5'h0;
      pinConfigUnlocked       <= 1'b0;
    end else if (extRstOn) begin
      pin_alt_function_select <= `DPMS_PIN_DEFAULT;
      pin_digital_enable      <= `DPMS_PIN_DEFAULT;
      pin_pullup_enable       <= `DPMS_PIN_DEFAULT;
      pin_commit_enable       <= 5'h0;
      pinConfigUnlocked       <= 1'b0;
    end else begin
      if (lockWrEn) pinConfigUnlocked <= (lockWrData == `DPMS_LOCK_KEY);
      if (commitWrEn && pinConfigUnlocked) pin_commit_enable <= commitWrData;
      if (afselWrEn && pinConfigUnlocked) begin
        // protected bits take the write only where commit is enabled; zero hands pin to gpio
        pin_alt_function_select <= (afselWrData & pin_commit_enable) |
                                   (pin_alt_function_select & ~pin_commit_enable);
      end
    end
  end
endmodule // dpms_debug_port

// ### src/dpms_defs.vh
// constants for the debug port mode switch block
// assumes inclusion by bare name from src/
`ifndef DPMS_DEFS_VH
`define DPMS_DEFS_VH
`define DPMS_IR_WIDTH       4
`define DPMS_IR_IDENT       4'hE
`define DPMS_IR_BYPASS      4'hF
`define DPMS_IR_DPACC       4'hA
`define DPMS_DR_WIDTH       32
`define DPMS_IDENT_VALUE    32'h00000001
`define DPMS_CODE_TO_SERIAL 16'hE79E
`define DPMS_CODE_TO_JTAG   16'hE73C
`define DPMS_HIGH_RUN_MIN   6'h32
`define DPMS_TLR_HIGH_RUN   3'h5
`define DPMS_ERASE_COUNT    4'hA
`define DPMS_PIN_COUNT      5
`define DPMS_PIN_DEFAULT    5'h1F
`define DPMS_LOCK_KEY       32'h4C4F434B
`define DPMS_ERASE_CYCLES   16'h0100
`endif

// ### src/dpms_tap_fsm.v
// tap controller state machine, advanced by sampled link clock rising edges
// assumes tckRise is a one-cycle pulse in core_clk domain, tms already synchronised
`timescale 1ns/10ps
module dpms_tap_fsm (
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire        testRst,
  input  wire        tckRise,
  input  wire        tms,
  output reg  [15:0] tapState
);
  localparam [15:0] S_TLR  = 16'h0001, S_IDLE = 16'h0002, S_SELDR = 16'h0004, S_CAPDR = 16'h0008,
                    S_SHDR = 16'h0010, S_EX1DR = 16'h0020, S_PDR = 16'h0040, S_EX2DR = 16'h0080,
                    S_UPDR = 16'h0100, S_SELIR = 16'h0200, S_CAPIR = 16'h0400, S_SHIR = 16'h0800,
                    S_EX1IR = 16'h1000, S_PIR = 16'h2000, S_EX2IR = 16'h4000, S_UPIR = 16'h8000;
  reg [15:0] next_tapState;

  always @* begin
    case (tapState)
      S_TLR:   next_tapState = tms ? S_TLR   : S_IDLE;
      S_IDLE:  next_tapState = tms ? S_SELDR : S_IDLE;
      S_SELDR: next_tapState = tms ? S_SELIR : S_CAPDR;
      S_CAPDR: next_tapState = tms ? S_EX1DR : S_SHDR;
      S_SHDR:  next_tapState = tms ? S_EX1DR : S_SHDR;
      S_EX1DR: next_tapState = tms ? S_UPDR  : S_PDR;
      S_PDR:   next_tapState = tms ? S_EX2DR : S_PDR;
      S_EX2DR: next_tapState = tms ? S_UPDR  : S_SHDR;
      S_UPDR:  next_tapState = tms ? S_SELDR : S_IDLE;
      S_SELIR: next_tapState = tms ? S_TLR   : S_CAPIR;
      S_CAPIR: next_tapState = tms ? S_EX1IR : S_SHIR;
      S_SHIR:  next_tapState = tms ? S_EX1IR : S_SHIR;
      S_EX1IR: next_tapState = tms ? S_UPIR  : S_PIR;
      S_PIR:   next_tapState = tms ? S_EX2IR : S_PIR;
      S_EX2IR: next_tapState = tms ? S_UPIR  : S_SHIR;
      S_UPIR:  next_tapState = tms ? S_SELDR : S_IDLE;
      default: next_tapState = S_TLR;
    endcase
  end

  // five high tms samples reach test-logic-reset from any state
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tapState <= S_TLR;
    end else if (testRst) begin
      tapState <= S_TLR;
    end else if (tckRise) begin
      tapState <= next_tapState;
    end
  end
endmodule // dpms_tap_fsm

// ### verif/dpms_probe.sv
// probe model on the link pins of the debug port mode switch block
// assumes the device samples on the link rising edge; clock idles low
`timescale 1ns/10ps
module dpms_probe (
  input  wire dataOut,
  output reg  linkClk,
  output reg  modeSelIn,
  output reg  dataIn
);
  initial begin
    linkClk = 1'b0;
    modeSelIn = 1'b1;
    dataIn = 1'b1;
  end
  // pins change while the clock is low; the data pin returns to its pull-up level
  task cyc(input t, input d, output q);
    begin
      modeSelIn = t;
      dataIn = d;
      #160 linkClk = 1'b1;
      #150 q = dataOut;
      #10 linkClk = 1'b0;
      dataIn = 1'b1;
    end
  endtask
  task high(input integer n);
    integer i;
    reg q;
    for (i = 0; i < n; i = i + 1) cyc(1'b1, 1'b1, q);
  endtask
  task code(input [15:0] v);
    integer i;
    reg q;
    for (i = 0; i < 16; i = i + 1) cyc(v[i], 1'b1, q);
  endtask
  // from idle: capture, shift n bits lsb first, update, back to idle
  task scan(input ir, input integer n, input [31:0] din, output [31:0] dout);
    integer i;
    reg q;
    begin
      cyc(1'b1, 1'b1, q);
      if (ir) cyc(1'b1, 1'b1, q);
      cyc(1'b0, 1'b1, q);
      cyc(1'b0, 1'b1, q);
      dout = 32'h0;
      for (i = 0; i < n; i = i + 1) begin
        cyc(i == n - 1, din[i], q);
        dout[i] = q;
      end
      cyc(1'b1, 1'b1, q);
      cyc(1'b0, 1'b1, q);
    end
  endtask
endmodule // dpms_probe

// ### verif/dpms_monitor.sv
// port-level checker for the debug port mode switch block
// assumes it is bound to dpms_debug_port and sees only its ports
`timescale 1ns/10ps
`include "dpms_defs.vh"
module dpms_monitor (
  input wire        core_clk,
  input wire        rst_b,
  input wire        testRst_b,
  input wire        extRst_b,
  input wire        afselWrEn,
  input wire [4:0]  afselWrData,
  input wire        commitWrEn,
  input wire        lockWrEn,
  input wire [31:0] lockWrData,
  input wire        dataOutEn,
  input wire [4:0]  pin_alt_function_select,
  input wire [4:0]  pin_digital_enable,
  input wire [4:0]  pin_pullup_enable,
  input wire [4:0]  pin_commit_enable,
  input wire        pinConfigUnlocked,
  input wire        serialWireMode,
  input wire        serialLineReset,
  input wire        massEraseReq,
  input wire        massEraseDone,
  input wire        nvRestoreReq,
  input wire [3:0]  instruction,
  input wire [31:0] dataHold
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_pin_defaults: assert property ((!extRst_b)[*5] |-> pin_alt_function_select == 5'h1F &&
    pin_digital_enable == 5'h1F && pin_pullup_enable == 5'h1F) else $error("pins not in debug function");
  a_locked_drop: assert property (extRst_b[*5] ##0 (afselWrEn && !pinConfigUnlocked)
    |=> $stable(pin_alt_function_select)) else $error("locked select write took effect");
  a_commit_mask: assert property (extRst_b[*5] ##0 (afselWrEn && pinConfigUnlocked) |=>
    pin_alt_function_select == (($past(afselWrData) & $past(pin_commit_enable)) |
    ($past(pin_alt_function_select) & ~$past(pin_commit_enable)))) else $error("select write mask wrong");
  a_commit_locked: assert property (extRst_b[*5] ##0 (commitWrEn && !pinConfigUnlocked)
    |=> $stable(pin_commit_enable)) else $error("locked commit write took effect");
  a_unlock_key: assert property (extRst_b[*5] ##0 lockWrEn |=>
    pinConfigUnlocked == ($past(lockWrData) == `DPMS_LOCK_KEY)) else $error("lock state wrong");
  a_erase_hold: assert property (massEraseReq && !massEraseDone |=> massEraseReq)
    else $error("erase request dropped early");
  a_restore_order: assert property (nvRestoreReq |-> !massEraseReq ##1 !nvRestoreReq)
    else $error("restore before erase finished");
  a_line_reset: assert property (serialLineReset |-> serialWireMode)
    else $error("line reset outside serial mode");
  a_trst_hold: assert property ((!testRst_b)[*6] |-> instruction == `DPMS_IR_IDENT && !dataOutEn)
    else $error("test reset not holding tap");
  a_hold_update: assert property (!$stable(dataHold) |-> !dataOutEn && !serialWireMode)
    else $error("holding register changed outside update");
  c_erase: cover property ($rose(massEraseReq));
  c_serial: cover property ($rose(serialWireMode));
  c_unlock: cover property ($rose(pinConfigUnlocked));
endmodule // dpms_monitor
bind dpms_debug_port dpms_monitor i_dpms_monitor (.core_clk, .rst_b, .testRst_b, .extRst_b, .afselWrEn,
  .afselWrData, .commitWrEn, .lockWrEn, .lockWrData, .dataOutEn, .pin_alt_function_select, .pin_digital_enable,
  .pin_pullup_enable, .pin_commit_enable, .pinConfigUnlocked, .serialWireMode, .serialLineReset, .massEraseReq,
  .massEraseDone, .nvRestoreReq, .instruction, .dataHold);

// ### verif/testbench.sv
// self-checking bench for dpms_debug_port with the probe model on its link pins
// assumes the probe model and the bound checker are compiled before it
`timescale 1ns/10ps
`include "dpms_defs.vh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module testbench;
  reg         core_clk = 0, rst_b = 0, testRst_b = 1, extRst_b = 1, massEraseDone = 0;
  reg  [4:0]  afselWrData = 0, commitWrData = 0;
  reg  [31:0] lockWrData = 0, dout;
  reg         afselWrEn = 0, commitWrEn = 0, lockWrEn = 0, q, sawLr = 0, sawNv = 0;
  reg  [52:0] rows [0:4];
  wire        linkClk, modeSelIn, dataIn, dataOut, dataOutEn, pinConfigUnlocked, serialWireMode;
  wire        serialLineReset, massEraseReq, nvRestoreReq;
  wire [4:0]  pin_alt_function_select, pin_digital_enable, pin_pullup_enable, pin_commit_enable;
  wire [3:0]  instruction;
  wire [31:0] dataHold;
  integer     i, compares = 0, mismatches = 0;
  dpms_debug_port i_dpms_debug_port (.core_clk, .rst_b, .linkClk, .modeSelIn, .dataIn, .testRst_b, .extRst_b,
    .dataOut, .dataOutEn, .modeSelOut(), .modeSelOutEn(), .afselWrData, .afselWrEn, .commitWrData, .commitWrEn,
    .lockWrData, .lockWrEn, .pin_alt_function_select, .pin_digital_enable, .pin_pullup_enable, .pin_commit_enable,
    .pinConfigUnlocked, .serialWireMode, .serialLineReset, .massEraseReq, .nvRestoreReq, .massEraseDone,
    .instruction, .dataHold);
  dpms_probe i_dpms_probe (.dataOut, .linkClk, .modeSelIn, .dataIn);
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (serialLineReset === 1'b1) sawLr <= 1'b1;
    if (nvRestoreReq === 1'b1) sawNv <= 1'b1;
  end
  task stop_test;
    begin
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // row: lock, commit, select data, then expected select, unlocked, commit
  task wr_row(input [52:0] r);
    begin
      @(posedge core_clk) #1;
      {lockWrData, commitWrData, afselWrData} = r[52:11];
      lockWrEn = 1;
      @(posedge core_clk) #1 lockWrEn = 0;
      commitWrEn = 1;
      @(posedge core_clk) #1 commitWrEn = 0;
      afselWrEn = 1;
      @(posedge core_clk) #1 afselWrEn = 0;
      `CHK("select", r[10:6], pin_alt_function_select)
      `CHK("unlocked", r[5], pinConfigUnlocked)
      `CHK("commit", r[4:0], pin_commit_enable)
    end
  endtask
  // alternating switch codes, each after a long high run
  task codes(input integer n0, input integer n1);
    for (i = n0; i < n1; i = i + 1) begin
      i_dpms_probe.high(50);
      i_dpms_probe.code(i % 2 ? `DPMS_CODE_TO_JTAG : `DPMS_CODE_TO_SERIAL);
    end
  endtask
  initial begin
    #3000000;
    mismatches++;
    stop_test;
  end
  initial begin
    rows[0] = {32'h0, 5'h1F, 5'h00, 5'h1F, 1'b0, 5'h00};
    rows[1] = {`DPMS_LOCK_KEY, 5'h03, 5'h00, 5'h1C, 1'b1, 5'h03};
    rows[2] = {`DPMS_LOCK_KEY, 5'h1F, 5'h00, 5'h00, 1'b1, 5'h1F};
    rows[3] = {`DPMS_LOCK_KEY, 5'h1F, 5'h1F, 5'h1F, 1'b1, 5'h1F};
    rows[4] = {32'h0, 5'h00, 5'h00, 5'h1F, 1'b0, 5'h1F};
    repeat (20) @(posedge core_clk);
    #1 rst_b = 1;
    repeat (4) @(posedge core_clk);
    `CHK("select rst", 5'h1F, pin_alt_function_select)
    `CHK("digital rst", 5'h1F, pin_digital_enable)
    `CHK("pullup rst", 5'h1F, pin_pullup_enable)
    `CHK("instr rst", `DPMS_IR_IDENT, instruction)
    for (i = 0; i < 5; i = i + 1) wr_row(rows[i]);
    i_dpms_probe.high(5);
    i_dpms_probe.cyc(1'b0, 1'b1, q);
    i_dpms_probe.scan(1'b0, 32, 32'h0, dout);
    `CHK("ident", `DPMS_IDENT_VALUE, dout)
    `CHK("tdo off", 1'b0, dataOutEn)
    i_dpms_probe.scan(1'b1, 4, {28'h0, `DPMS_IR_DPACC}, dout);
    i_dpms_probe.scan(1'b0, 32, 32'hA5C30F96, dout);
    `CHK("instr", `DPMS_IR_DPACC, instruction)
    `CHK("hold", 32'hA5C30F96, dataHold)
    @(posedge core_clk) #1 testRst_b = 0;
    repeat (6) @(posedge core_clk);
    #1 `CHK("instr trst", `DPMS_IR_IDENT, instruction)
    testRst_b = 1;
    repeat (4) @(posedge core_clk);
    i_dpms_probe.cyc(1'b0, 1'b1, q);
    i_dpms_probe.scan(1'b1, 4, {28'h0, `DPMS_IR_BYPASS}, dout);
    i_dpms_probe.scan(1'b0, 9, 32'h0AD, dout);
    `CHK("bypass", 8'hAD, dout[8:1])
    i_dpms_probe.high(20);
    i_dpms_probe.code(`DPMS_CODE_TO_SERIAL);
    repeat (4) @(posedge core_clk);
    `CHK("short run", 1'b0, serialWireMode)
    codes(0, 1);
    repeat (4) @(posedge core_clk);
    `CHK("serial", 1'b1, serialWireMode)
    sawLr = 0;
    i_dpms_probe.high(50);
    `CHK("line reset", 1'b1, sawLr)
    codes(1, 2);
    i_dpms_probe.high(5);
    repeat (4) @(posedge core_clk);
    `CHK("jtag", 1'b0, serialWireMode)
    `CHK("instr tlr", `DPMS_IR_IDENT, instruction)
    @(posedge core_clk) #1 extRst_b = 0;
    repeat (4) @(posedge core_clk);
    codes(0, 3);
    @(posedge core_clk) #1 extRst_b = 1;
    repeat (8) @(posedge core_clk);
    #1 extRst_b = 0;
    repeat (4) @(posedge core_clk);
    codes(0, 9);
    repeat (8) @(posedge core_clk);
    `CHK("early erase", 1'b0, massEraseReq)
    codes(9, 10);
    for (i = 0; i < 20 && massEraseReq !== 1'b1; i = i + 1) @(posedge core_clk) #1;
    `CHK("erase", 1'b1, massEraseReq)
    sawNv = 0;
    massEraseDone = 1;
    for (i = 0; i < 10 && sawNv !== 1'b1; i = i + 1) @(posedge core_clk) #1;
    `CHK("restore", 1'b1, sawNv)
    `CHK("erase off", 1'b0, massEraseReq)
    massEraseDone = 0;
    extRst_b = 1;
    repeat (8) @(posedge core_clk);
    stop_test;
  end
endmodule // testbench
